// [common/key_reader_pkg.sv]
// Shared constants and types for the key reader process data and indicator logic.
package key_reader_pkg;

	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

	// Input image byte offsets and the single output image offset.
	localparam int unsigned IN_IMAGE_BYTES = 8;
	localparam logic [2:0] OFS_KEY_FORMAT_BYTE = 3'h0;
	localparam logic [2:0] OFS_KEY_IDENT_BYTE_ONE = 3'h1;
	localparam logic [2:0] OFS_KEY_IDENT_BYTE_TWO = 3'h2;
	localparam logic [2:0] OFS_KEY_IDENT_BYTE_THREE = 3'h3;
	localparam logic [2:0] OFS_KEY_IDENT_BYTE_FOUR = 3'h4;
	localparam logic [2:0] OFS_KEY_IDENT_BYTE_FIVE = 3'h5;
	localparam logic [2:0] OFS_KEY_IDENT_BYTE_SIX = 3'h6;
	localparam logic [2:0] OFS_KEY_CHECK_BYTE = 3'h7;
	localparam logic [2:0] OFS_INDICATOR_CONTROL_BYTE = 3'h0;

	// Indicator control values and reset value.
	localparam logic [7:0] CTRL_OWN_STATUS = 8'h00;
	localparam logic [7:0] CTRL_FORCE_RED = 8'h01;
	localparam logic [7:0] CTRL_FORCE_GREEN = 8'h02;
	localparam logic [7:0] CTRL_RESET_VALUE = 8'h00;

	// Blink timing: 5 Hz and 1 Hz periods, and the single-flash period and lit time.
	localparam int unsigned FAST_BLINK_PERIOD_MS = 200;
	localparam int unsigned SLOW_BLINK_PERIOD_MS = 1000;
	localparam int unsigned FLASH_PERIOD_MS = 1000;
	localparam int unsigned FLASH_ON_MS = 100;
	localparam int unsigned FAST_BLINK_CYCLES = CYC_PER_MS * FAST_BLINK_PERIOD_MS;
	localparam int unsigned SLOW_BLINK_CYCLES = CYC_PER_MS * SLOW_BLINK_PERIOD_MS;
	localparam int unsigned FLASH_PERIOD_CYCLES = CYC_PER_MS * FLASH_PERIOD_MS;
	localparam int unsigned FLASH_ON_CYCLES = CYC_PER_MS * FLASH_ON_MS;

	// Offset 0 occupies the low byte, offset 7 the high byte.
	typedef struct packed {
		logic [7:0]  check;
		logic [47:0] ident;
		logic [7:0]  format;
	} key_image_t;

	typedef struct packed {
		logic red;
		logic green;
	} led_drive_t;

	localparam key_image_t IMAGE_RESET_VALUE = '0;
	localparam led_drive_t LED_RESET_VALUE = '0;

	typedef enum logic [2:0] {
		ST_IDLE      = 3'b000,
		ST_READING   = 3'b001,
		ST_READ_OK   = 3'b010,
		ST_READ_FAIL = 3'b011,
		ST_WRITING   = 3'b100,
		ST_WRITE_OK  = 3'b101
	} reader_state_t;

endpackage : key_reader_pkg

// [design/blink_timer.sv]
// Free-running period counter that yields one blink phase for the indicator.
`timescale 1ns/1ns
module blink_timer #(
	parameter int unsigned PERIOD_CYC = 10,
	parameter int unsigned HIGH_CYC   = 5
) (
	input  wire logic ref_clk_in,
	input  wire logic rst_in,
	input  wire logic ce_in,
	output logic      phase_out
);

	localparam int unsigned CW = (PERIOD_CYC > 2) ? $clog2(PERIOD_CYC) : 1;
	localparam logic [CW-1:0] LAST = CW'(PERIOD_CYC - 1);
	localparam logic [CW-1:0] HIGH = CW'(HIGH_CYC);

	logic [CW-1:0] count_r;
	logic [CW-1:0] count_nxt;

	generate
		if (PERIOD_CYC < 2 || HIGH_CYC < 1 || HIGH_CYC >= PERIOD_CYC) begin : g_bad
			$error("blink_timer: period must exceed lit time, both nonzero");
		end
	endgenerate

	assign count_nxt = (count_r == LAST) ? '0 : count_r + 1'b1;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			count_r <= '0;
		end else if (ce_in) begin
			count_r <= count_nxt;
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			phase_out <= 1'b0;
		end else if (ce_in) begin
			phase_out <= (count_nxt < HIGH);
		end
	end

	a_count_bound: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		count_r <= LAST)
		else $error("blink counter ran past its period");

	a_count_wrap: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		ce_in && count_r == LAST |=> count_r == '0)
		else $error("blink counter did not wrap at period end");

endmodule : blink_timer

// [design/key_reader_process_data_indicator.sv]
// Process image and status indicator logic of the contact key reader fieldbus slave.
// What this block does
// - Input image is eight bytes at offsets 0-7; output image one byte.
// - Format byte at 0, six ident bytes at 1-6, check byte at 7.
// - No key or failed read drives all eight input bytes to zero.
// - Identifier reported every exchange while key stays; cleared when key leaves.
// - Output byte 0 is the front indicator control value.
// - Control value 0x01 forces steady red over the normal pattern.
// - Control value 0x02 forces steady green over the normal pattern.
// - Control values 0x00 and 0x03-0xff leave the own status pattern.
// - Forcing is ignored during a fault; the fault pattern stays shown.
// - Green single flash idle, 5 Hz reading, 1 Hz after good read.
// - Red single flash while not operational: configuration missing, bad, unfinished.
// - Red 1 Hz on read failure or contact fault without key.
// - Green/red alternating 5 Hz while writing, 1 Hz after good write.
// - Orange 5 Hz during takeover, both LEDs off during reset; orange 1 Hz on bus failure.
// - Rear bus indicator off without bus error, steady red with one.
`timescale 1ns/1ns
module key_reader_process_data_indicator
	import key_reader_pkg::*;
#(
	parameter int unsigned FAST_BLINK_CYC = FAST_BLINK_CYCLES,
	parameter int unsigned SLOW_BLINK_CYC = SLOW_BLINK_CYCLES,
	parameter int unsigned FLASH_CYC      = FLASH_PERIOD_CYCLES,
	parameter int unsigned FLASH_ON_CYC   = FLASH_ON_CYCLES
) (
	input  wire logic       ref_clk_in,
	input  wire logic       rst_in,
	input  wire logic       ce_in,
	input  wire logic       key_contact_in,
	input  wire logic       read_busy_in,
	input  wire logic       read_done_in,
	input  wire logic       read_err_in,
	input  wire key_image_t read_image_in,
	input  wire logic       write_busy_in,
	input  wire logic       write_done_in,
	input  wire logic       write_err_in,
	input  wire logic       contact_fault_in,
	input  wire logic       not_operating_in,
	input  wire logic       takeover_in,
	input  wire logic       bus_comm_fail_in,
	input  wire logic       bus_error_in,
	input  wire logic       ctrl_write_in,
	input  wire logic [7:0] ctrl_byte_in,
	input  wire logic [2:0] image_offset_in,
	output key_image_t      in_image_out,
	output logic [7:0]      image_byte_out,
	output logic [7:0]      indicator_control_out,
	output led_drive_t      status_led_out,
	output logic            bus_fault_indicator_out
);

	generate
		if (FAST_BLINK_CYC >= SLOW_BLINK_CYC || FLASH_ON_CYC >= FLASH_CYC
			|| FAST_BLINK_CYC < 2) begin : g_bad
			$error("key reader: blink timing parameters are inconsistent");
		end
	endgenerate

	logic          key_meta_r;
	logic          key_sync_r;
	reader_state_t state_r;
	reader_state_t state_nxt;
	key_image_t    image_r;
	key_image_t    image_nxt;
	logic [7:0]    ctrl_r;
	led_drive_t    led_r;
	led_drive_t    led_nxt;
	logic          fast_w;
	logic          slow_w;
	logic          flash_w;
	logic          fault_w;
	logic          image_valid_w;

	// The key sense contact is asynchronous to the system clock.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			key_meta_r <= 1'b0;
			key_sync_r <= 1'b0;
		end else if (ce_in) begin
			key_meta_r <= key_contact_in;
			key_sync_r <= key_meta_r;
		end
	end

	blink_timer #(
		.PERIOD_CYC (FAST_BLINK_CYC),
		.HIGH_CYC   (FAST_BLINK_CYC / 2)
	) u_fast (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.ce_in      (ce_in),
		.phase_out  (fast_w)
	);

	blink_timer #(
		.PERIOD_CYC (SLOW_BLINK_CYC),
		.HIGH_CYC   (SLOW_BLINK_CYC / 2)
	) u_slow (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.ce_in      (ce_in),
		.phase_out  (slow_w)
	);

	blink_timer #(
		.PERIOD_CYC (FLASH_CYC),
		.HIGH_CYC   (FLASH_ON_CYC)
	) u_flash (
		.ref_clk_in (ref_clk_in),
		.rst_in     (rst_in),
		.ce_in      (ce_in),
		.phase_out  (flash_w)
	);

	// Reader sequence. Losing the key always returns to idle, whatever the step.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (key_sync_r && read_busy_in) begin
					state_nxt = ST_READING;
				end
			end
			ST_READING: begin
				if (!key_sync_r) begin
					state_nxt = ST_IDLE;
				end else if (read_done_in) begin
					state_nxt = read_err_in ? ST_READ_FAIL : ST_READ_OK;
				end
			end
			ST_READ_OK: begin
				if (!key_sync_r) begin
					state_nxt = ST_IDLE;
				end else if (write_busy_in) begin
					state_nxt = ST_WRITING;
				end
			end
			ST_WRITING: begin
				if (!key_sync_r) begin
					state_nxt = ST_IDLE;
				end else if (write_done_in) begin
					state_nxt = write_err_in ? ST_READ_FAIL : ST_WRITE_OK;
				end
			end
			ST_WRITE_OK,
			ST_READ_FAIL: begin
				if (!key_sync_r) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_r <= ST_IDLE;
		end else if (ce_in) begin
			state_r <= state_nxt;
		end
	end

	assign image_valid_w = (state_nxt == ST_READ_OK) || (state_nxt == ST_WRITING)
		|| (state_nxt == ST_WRITE_OK);

	always_comb begin
		image_nxt = image_r;
		if (state_r == ST_READING && state_nxt == ST_READ_OK) begin
			image_nxt = read_image_in;
		end
		if (!image_valid_w) begin
			image_nxt = IMAGE_RESET_VALUE;
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			image_r <= IMAGE_RESET_VALUE;
		end else if (ce_in) begin
			image_r <= image_nxt;
		end
	end

	assign in_image_out = image_r;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			image_byte_out <= 8'h00;
		end else if (ce_in) begin
			case (image_offset_in)
				OFS_KEY_FORMAT_BYTE:      image_byte_out <= image_r.format;
				OFS_KEY_IDENT_BYTE_ONE:   image_byte_out <= image_r.ident[7:0];
				OFS_KEY_IDENT_BYTE_TWO:   image_byte_out <= image_r.ident[15:8];
				OFS_KEY_IDENT_BYTE_THREE: image_byte_out <= image_r.ident[23:16];
				OFS_KEY_IDENT_BYTE_FOUR:  image_byte_out <= image_r.ident[31:24];
				OFS_KEY_IDENT_BYTE_FIVE:  image_byte_out <= image_r.ident[39:32];
				OFS_KEY_IDENT_BYTE_SIX:   image_byte_out <= image_r.ident[47:40];
				OFS_KEY_CHECK_BYTE:       image_byte_out <= image_r.check;
				default:                  image_byte_out <= 8'h00;
			endcase
		end
	end

	// control byte capture
	// The last value written stays in force until the master writes another.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl_r <= CTRL_RESET_VALUE;
		end else if (ce_in && ctrl_write_in) begin
			ctrl_r <= ctrl_byte_in;
		end
	end

	assign indicator_control_out = ctrl_r;

	// A contact short only counts as a fault while no key sits on the contacts.
	assign fault_w = takeover_in || not_operating_in || bus_comm_fail_in
		|| (state_r == ST_READ_FAIL) || (contact_fault_in && !key_sync_r);

	// Pattern priority runs from the most severe condition to the quietest.
	always_comb begin
		led_nxt = LED_RESET_VALUE;
		if (takeover_in) begin
			led_nxt.red = fast_w;
			led_nxt.green = fast_w;
		end else if (not_operating_in) begin
			led_nxt.red = flash_w;
		end else if (bus_comm_fail_in) begin
			led_nxt.red = slow_w;
			led_nxt.green = slow_w;
		end else if (fault_w) begin
			led_nxt.red = slow_w;
		end else if (ctrl_r == CTRL_FORCE_RED) begin
			led_nxt.red = 1'b1;
		end else if (ctrl_r == CTRL_FORCE_GREEN) begin
			led_nxt.green = 1'b1;
		end else begin
			case (state_r)
				ST_IDLE: begin
					led_nxt.green = flash_w;
				end
				ST_READING: begin
					led_nxt.green = fast_w;
				end
				ST_READ_OK: begin
					led_nxt.green = slow_w;
				end
				ST_WRITING: begin
					led_nxt.green = fast_w;
					led_nxt.red = !fast_w;
				end
				ST_WRITE_OK: begin
					led_nxt.green = slow_w;
					led_nxt.red = !slow_w;
				end
				default: begin
					led_nxt = LED_RESET_VALUE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			led_r <= LED_RESET_VALUE;
		end else if (ce_in) begin
			led_r <= led_nxt;
		end
	end

	assign status_led_out = led_r;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			bus_fault_indicator_out <= 1'b0;
		end else if (ce_in) begin
			bus_fault_indicator_out <= bus_error_in;
		end
	end

	a_absent_clears: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		ce_in && !key_sync_r |=> in_image_out == IMAGE_RESET_VALUE)
		else $error("input image not cleared with key absent");

	a_fail_clears: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		ce_in && state_r == ST_READ_FAIL |=> in_image_out == IMAGE_RESET_VALUE)
		else $error("input image not zero after failed read");

	a_ident_capture: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		ce_in && state_r == ST_READING && key_sync_r && read_done_in && !read_err_in
		|=> in_image_out == $past(read_image_in))
		else $error("identifier not captured on good read");

	a_byte_select: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		ce_in && image_offset_in == OFS_KEY_CHECK_BYTE
		|=> image_byte_out == $past(image_r.check))
		else $error("check byte not presented at its offset");

	a_ctrl_capture: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		ce_in && ctrl_write_in |=> indicator_control_out == $past(ctrl_byte_in))
		else $error("control byte not captured");

	a_force_red: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		ce_in && !fault_w && ctrl_r == CTRL_FORCE_RED
		|=> status_led_out.red && !status_led_out.green)
		else $error("forced red not shown");

	a_force_green: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		ce_in && !fault_w && ctrl_r == CTRL_FORCE_GREEN
		|=> status_led_out.green && !status_led_out.red)
		else $error("forced green not shown");

	a_fault_blocks: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		ce_in && not_operating_in && !takeover_in && ctrl_r == CTRL_FORCE_GREEN
		|=> !status_led_out.green && status_led_out.red == $past(flash_w))
		else $error("force applied during a fault");

	a_idle_flash: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		ce_in && !fault_w && state_r == ST_IDLE && ctrl_r != CTRL_FORCE_RED
		&& ctrl_r != CTRL_FORCE_GREEN
		|=> status_led_out.green == $past(flash_w) && !status_led_out.red)
		else $error("idle single flash wrong");

	a_write_alt: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		ce_in && !fault_w && state_r == ST_WRITING && ctrl_r == CTRL_OWN_STATUS
		|=> status_led_out.green != status_led_out.red)
		else $error("write pattern does not alternate colours");

	a_bus_light: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		ce_in |=> bus_fault_indicator_out == $past(bus_error_in))
		else $error("bus indicator does not follow bus error");

	a_freeze: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		!ce_in |=> $stable(state_r) && $stable(status_led_out) && $stable(image_r))
		else $error("state moved with clock enable low");

endmodule : key_reader_process_data_indicator

// [testbench/bus_master_model.sv]
// Cyclic bus master model that writes the control byte and scans the input image.
`timescale 1ns/1ns
module bus_master_model (
	input  wire logic       ref_clk_in,
	input  wire logic       rst_in,
	input  wire logic       start_in,
	input  wire logic [7:0] ctrl_value_in,
	input  wire logic [7:0] image_byte_in,
	output logic            ctrl_write_out,
	output logic [7:0]      ctrl_byte_out,
	output logic [2:0]      image_offset_out,
	output logic            rd_valid_out,
	output logic [7:0]      rd_byte_out,
	output logic            busy_out
);
	logic [3:0] cnt_r;

	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl_write_out <= 1'b0;
			ctrl_byte_out <= 8'h00;
			image_offset_out <= 3'h0;
			rd_valid_out <= 1'b0;
			rd_byte_out <= 8'h00;
			busy_out <= 1'b0;
			cnt_r <= 4'h0;
		end else begin
			ctrl_write_out <= 1'b0;
			rd_valid_out <= 1'b0;
			// Unqualified lines keep moving so that a stale value is never mistaken for data.
			ctrl_byte_out <= ~ctrl_byte_out;
			image_offset_out <= image_offset_out + 3'h1;
			if (start_in && !busy_out) begin
				ctrl_write_out <= 1'b1;
				ctrl_byte_out <= ctrl_value_in;
				image_offset_out <= 3'h0;
				cnt_r <= 4'h0;
				busy_out <= 1'b1;
			end else if (busy_out) begin
				cnt_r <= cnt_r + 4'h1;
				if (cnt_r < 4'h7) begin
					image_offset_out <= cnt_r[2:0] + 3'h1;
				end
				if (cnt_r != 4'h0) begin
					rd_valid_out <= 1'b1;
					rd_byte_out <= image_byte_in;
				end
				if (cnt_r == 4'h8) begin
					busy_out <= 1'b0;
				end
			end
		end
	end
endmodule : bus_master_model

// [testbench/testbench.sv]
// Self-checking bench for the key reader process image and indicator logic.
`timescale 1ns/1ns
module testbench
	import key_reader_pkg::*;
;
	localparam int FAST = 10;
	localparam int SLOW = 50;
	localparam int FL_ON = 5;
	localparam int L = SLOW / 2;
	localparam int T5 = 2 * SLOW / FAST;

	logic ref_clk_in, rst_in, ce_in, key, rd_busy, rd_done, rd_err, wr_busy, wr_done, wr_err;
	logic c_fault, not_op, takeover, comm_fail, bus_err, start;
	logic [7:0] ctrl_val;
	key_image_t rd_img, img, in_image;
	wire logic ctrl_wr, rd_valid, busy, bus_ind;
	wire logic [7:0] ctrl_byte, img_byte_w, ctrl_out, rd_byte;
	wire logic [2:0] ofs;
	wire led_drive_t indicator_control_byte;
	led_drive_t held;
	int error_cnt;
	int checks;
	logic [7:0] exp_q[$];

	key_reader_process_data_indicator #(.FAST_BLINK_CYC(FAST), .SLOW_BLINK_CYC(SLOW),
		.FLASH_CYC(SLOW), .FLASH_ON_CYC(FL_ON)) key_reader_process_data_indicator_i (
		.ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(ce_in), .key_contact_in(key),
		.read_busy_in(rd_busy), .read_done_in(rd_done), .read_err_in(rd_err),
		.read_image_in(rd_img), .write_busy_in(wr_busy), .write_done_in(wr_done),
		.write_err_in(wr_err), .contact_fault_in(c_fault), .not_operating_in(not_op),
		.takeover_in(takeover), .bus_comm_fail_in(comm_fail), .bus_error_in(bus_err),
		.ctrl_write_in(ctrl_wr), .ctrl_byte_in(ctrl_byte), .image_offset_in(ofs),
		.in_image_out(in_image), .image_byte_out(img_byte_w),
		.indicator_control_out(ctrl_out), .status_led_out(indicator_control_byte),
		.bus_fault_indicator_out(bus_ind));

	bus_master_model bus_master_model_i (
		.ref_clk_in(ref_clk_in), .rst_in(rst_in), .start_in(start), .ctrl_value_in(ctrl_val),
		.image_byte_in(img_byte_w), .ctrl_write_out(ctrl_wr), .ctrl_byte_out(ctrl_byte),
		.image_offset_out(ofs), .rd_valid_out(rd_valid), .rd_byte_out(rd_byte),
		.busy_out(busy));

	initial begin
		ref_clk_in = 1'b0;
		forever #10 ref_clk_in = ~ref_clk_in;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic conclude;
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude

	function automatic logic [7:0] exp_byte(input key_image_t v, input int k);
		if (k == 0) return v.format;
		if (k == 7) return v.check;
		return v.ident[(k - 1) * 8 +: 8];
	endfunction : exp_byte

	// Each byte the master reads is compared with the oldest note.
	always @(negedge ref_clk_in) begin
		if (rd_valid === 1'b1) begin
			if (exp_q.size() == 0)
				check({24'h0, rd_byte}, 32'hdead);
			else
				check({24'h0, rd_byte}, {24'h0, exp_q.pop_front()});
		end
	end

	task automatic exchange(input logic [7:0] c, input key_image_t v);
		int n;
		@(posedge ref_clk_in);
		start <= 1'b1;
		ctrl_val <= c;
		for (int k = 0; k < 8; k++) exp_q.push_back(exp_byte(v, k));
		@(posedge ref_clk_in);
		start <= 1'b0;
		for (n = 0; n < 20; n++) begin
			@(negedge ref_clk_in);
			if (busy === 1'b0) break;
		end
		if (n == 20) begin
			error_cnt++;
			conclude();
		end
		@(posedge ref_clk_in);
	endtask : exchange

	// Counts lit samples and changes over one slow period, so blink phase does not matter.
	task automatic pattern(input int eg, input int er, input int egt, input int ert);
		logic [7:0] g = 8'h0, r = 8'h0, gt = 8'h0, rt = 8'h0;
		led_drive_t p;
		repeat (4) @(negedge ref_clk_in);
		p = indicator_control_byte;
		for (int i = 0; i < SLOW; i++) begin
			g = g + 8'(p.green);
			r = r + 8'(p.red);
			@(negedge ref_clk_in);
			gt = gt + 8'(indicator_control_byte.green !== p.green);
			rt = rt + 8'(indicator_control_byte.red !== p.red);
			p = indicator_control_byte;
		end
		check({g, r, gt, rt}, {8'(eg), 8'(er), 8'(egt), 8'(ert)});
		@(posedge ref_clk_in);
	endtask : pattern

	task automatic read_key(input logic err);
		key <= 1'b1;
		repeat (4) @(posedge ref_clk_in);
		rd_busy <= 1'b1;
		if (!err) pattern(L, 0, T5, 0);
		@(posedge ref_clk_in);
		rd_done <= 1'b1;
		rd_err <= err;
		rd_img <= img;
		@(posedge ref_clk_in);
		rd_done <= 1'b0;
		rd_busy <= 1'b0;
		rd_img <= ~img;
	endtask : read_key

	initial begin
		void'($urandom(32'h87a923ee));
		{key, rd_busy, rd_done, rd_err, wr_busy, wr_done, wr_err} = '0;
		{c_fault, not_op, takeover, comm_fail, bus_err, start} = '0;
		ctrl_val = 8'h00;
		rd_img = '0;
		ce_in = 1'b1;
		rst_in = 1'b1;
		error_cnt = 0;
		checks = 0;
		repeat (2) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		pattern(FL_ON, 0, 2, 0);
		exchange(CTRL_FORCE_RED, '0);
		check({24'h0, ctrl_out}, {24'h0, CTRL_FORCE_RED});
		pattern(0, SLOW, 0, 0);
		exchange(CTRL_FORCE_GREEN, '0);
		pattern(SLOW, 0, 0, 0);
		exchange(8'($urandom_range(255, 3)), '0);
		pattern(FL_ON, 0, 2, 0);
		exchange(CTRL_OWN_STATUS, '0);
		pattern(FL_ON, 0, 2, 0);
		img = {$urandom, $urandom};
		read_key(1'b0);
		exchange(CTRL_OWN_STATUS, img);
		check(in_image[31:0], img[31:0]);
		check(in_image[63:32], img[63:32]);
		exchange(CTRL_OWN_STATUS, img);
		pattern(L, 0, 2, 0);
		@(posedge ref_clk_in);
		wr_busy <= 1'b1;
		pattern(L, L, T5, T5);
		@(posedge ref_clk_in);
		wr_done <= 1'b1;
		wr_busy <= 1'b0;
		@(posedge ref_clk_in);
		wr_done <= 1'b0;
		pattern(L, L, 2, 2);
		key <= 1'b0;
		repeat (4) @(posedge ref_clk_in);
		exchange(CTRL_OWN_STATUS, '0);
		check(in_image[63:32] | in_image[31:0], 32'h0);
		read_key(1'b1);
		exchange(CTRL_FORCE_RED, '0);
		pattern(0, L, 0, 2);
		exchange(CTRL_OWN_STATUS, '0);
		key <= 1'b0;
		c_fault <= 1'b1;
		pattern(0, L, 0, 2);
		c_fault <= 1'b0;
		not_op <= 1'b1;
		exchange(CTRL_FORCE_GREEN, '0);
		pattern(0, FL_ON, 0, 2);
		not_op <= 1'b0;
		pattern(SLOW, 0, 0, 0);
		exchange(CTRL_OWN_STATUS, '0);
		comm_fail <= 1'b1;
		pattern(L, L, 2, 2);
		comm_fail <= 1'b0;
		takeover <= 1'b1;
		pattern(L, L, T5, T5);
		// With the enable low a running fast blink would show its inverse after 15 cycles.
		ce_in <= 1'b0;
		@(negedge ref_clk_in);
		held = indicator_control_byte;
		repeat (15) @(negedge ref_clk_in);
		check({30'h0, indicator_control_byte}, {30'h0, held});
		@(posedge ref_clk_in);
		ce_in <= 1'b1;
		takeover <= 1'b0;
		@(posedge ref_clk_in);
		bus_err <= 1'b1;
		@(negedge ref_clk_in);
		check({31'h0, bus_ind}, 32'h0);
		@(negedge ref_clk_in);
		check({31'h0, bus_ind}, 32'h1);
		@(posedge ref_clk_in);
		bus_err <= 1'b0;
		repeat (2) @(negedge ref_clk_in);
		check({31'h0, bus_ind}, 32'h0);
		// A failed key write falls back to the failed-read pattern with the image cleared.
		@(posedge ref_clk_in);
		read_key(1'b0);
		wr_busy <= 1'b1;
		@(posedge ref_clk_in);
		{wr_busy, wr_done, wr_err} <= 3'b011;
		@(posedge ref_clk_in);
		{wr_done, wr_err} <= 2'b00;
		exchange(CTRL_OWN_STATUS, '0);
		pattern(0, L, 0, 2);
		conclude();
	end
endmodule : testbench
